// File: common/servo_consts.svh
`ifndef SERVO_CONSTS_SVH
`define SERVO_CONSTS_SVH
// Clock rate and times
`define CLK_KHZ 10000
`define TRK_HOLD_MS 50
`define HOLD_CYCLES (`TRK_HOLD_MS * `CLK_KHZ)
`define CTRL_DIV 16
// Host command codes
`define CMD_SPINDLE 3'h1
`define CMD_FOCUS_SEARCH 3'h2
`define CMD_FOCUS_OFF 3'h3
`define CMD_JUMP 3'h4
`define CMD_BRAKE_LEN 3'h5
// Command argument fields
`define ARG_DIR_BIT 7
`define ARG_SEL_LSB 0
`define BRAKE_LEN_RST 8'h20
// Drive levels
`define SEARCH_STEP 12'sh004
`define SEARCH_LIMIT 12'sh400
`define JUMP_KICK 12'sh300
`define BRAKE_DRIVE 12'sh200
`define SPIN_KICK 12'sh7ff
`define SPIN_OFFSET 12'sh100
`define SPIN_BRAKE 12'sh800
`define ROUGH_HIGH 12'sh400
`define ROUGH_LOW 12'shc00
// Carriage path
`define LPF_SHIFT 4
`define CARR_GAIN_SHIFT 2
`define CARR_THRESH 16'h0200
// Demodulator figures
`define SYNC_PERIOD 16
`define SYNC_MISS_MAX 8
`define RUN_WINDOW 8'hff
`define SLOW_RUN 8'h40
`define NOMINAL_RUN 8'h20
`endif

// File: common/servo_pkg.sv
package servo_pkg;
	typedef logic signed [11:0] drive_t;
	typedef enum logic [2:0] {SP_STOP, SP_KICK, SP_OFFSET, SP_APPLIC,
		SP_BRAKE, SP_ROUGH} spindle_mode_t;
	typedef enum logic [1:0] {FOC_IDLE, FOC_SEARCH, FOC_CLOSED
		} focus_state_t;
	typedef enum logic [1:0] {JMP_IDLE, JMP_RUN, JMP_BRAKE, JMP_HOLD
		} jump_state_t;
endpackage

// File: common/sync_if.sv
`timescale 1ns/100ps
interface sync_if;
	logic sampleTick;
	logic match;
	logic locked;
	modport mon (output sampleTick, output match, output locked);
	modport seq (input sampleTick, input match, input locked);
endinterface

// File: src/frame_sync_monitor.sv
`timescale 1ns/100ps
`include "servo_consts.svh"
module frame_sync_monitor
	import servo_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// Demodulator inputs
	input  wire logic writeFrameClock,
	input  wire logic frameSyncIn,
	input  wire logic frameCountIn,
	// Result toward the sequencer
	sync_if.mon       sync
);
	logic       wfcPrev_q, wfcPrev_d;
	logic [3:0] divCnt_q, divCnt_d;
	logic [3:0] miss_q, miss_d;
	logic       match_q, match_d;
	logic       tick_q, tick_d;
	logic       wfcEdge;

	// Compare once per sixteen frame clocks, count runs of misses
	always_comb
	begin
		wfcEdge = writeFrameClock && !wfcPrev_q;
		wfcPrev_d = writeFrameClock;
		divCnt_d = divCnt_q;
		miss_d = miss_q;
		match_d = match_q;
		tick_d = 1'b0;
		if (wfcEdge)
		begin
			divCnt_d = divCnt_q + 4'h1;
			if (divCnt_q == 4'(`SYNC_PERIOD - 1))
			begin
				tick_d = 1'b1;
				match_d = (frameSyncIn == frameCountIn);
				if (match_d)
					miss_d = 4'h0;
				else if (miss_q < 4'(`SYNC_MISS_MAX))
					miss_d = miss_q + 4'h1;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			wfcPrev_q <= 1'b0;
			divCnt_q <= 4'h0;
			miss_q <= 4'h0;
			match_q <= 1'b1;
			tick_q <= 1'b0;
		end
		else
		begin
			wfcPrev_q <= wfcPrev_d;
			divCnt_q <= divCnt_d;
			miss_q <= miss_d;
			match_q <= match_d;
			tick_q <= tick_d;
		end
	end

	// Lock holds until eight misses in a row
	assign sync.sampleTick = tick_q;
	assign sync.match = match_q;
	assign sync.locked = (miss_q < 4'(`SYNC_MISS_MAX));

	AST_LOCK_LOSS: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		$fell(sync.locked) |-> tick_q && !match_q)
		else $error("frame lock dropped without a miss");
endmodule

// File: src/optical_disc_servo_sequencer.sv
// Behaviour
// - Triangle focus search while spindle kicked.
// - Close focus: approaching, reflection present, zero-cross latched.
// - Focus-closed output falls on close.
// - Automatic jumps of 1,4,10,32,32x3 tracks.
// - Preset half distance, count zero-crosses down.
// - Count done: commanded brake pulse, close tracking.
// - Tracking brake and gain boost 50 ms.
// - Brake drives only against lens slip.
// - Carriage: low-pass tracking, fixed gain.
// - Carriage drive only above threshold.
// - Kick mode accelerates disc.
// - Offset mode holds speed, incl. focus loss.
// - Frame sync compared every sixteen frame clocks.
// - Lock lost only after eight misses.
// - Applicable mode picks locked or regular servo.
// - Brake mode flags slow rotation by run.
// - Stop mode drives spindle to zero.
// - Rough servo: run length gives high/low.
// - Off-track indicator low on track.
`timescale 1ns/100ps
`include "servo_consts.svh"
module optical_disc_servo_sequencer
	import servo_pkg::*;
#(
	parameter int HOLD_CYCLES = `HOLD_CYCLES
)
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Host command
	input  wire logic        cmdValid,
	input  wire logic [2:0]  cmdCode,
	input  wire logic [7:0]  cmdArg,
	output logic             cmdReady,
	// Focus sensing
	input  wire drive_t      focusError,
	input  wire drive_t      focusZeroThreshold,
	input  wire logic        reflectPresentFlag,
	// Tracking sensing
	input  wire logic        trackZeroCross,
	input  wire logic        offTrackIndicator,
	input  wire drive_t      trackingEqOut,
	// Demodulator
	input  wire logic        writeFrameClock,
	input  wire logic        frameSyncIn,
	input  wire logic        frameCountIn,
	input  wire logic        efmBit,
	input  wire drive_t      spinErrLocked,
	input  wire drive_t      spinErrRegular,
	// Focus outputs
	output drive_t           focusDrive,
	output logic             focusLoopOn,
	output logic             focusClosed_n,
	// Tracking outputs
	output drive_t           trackDrive,
	output logic             trackLoopOn,
	output logic             trackGainBoost,
	output logic             jumpBusy,
	// Carriage and spindle outputs
	output drive_t           carriageDrive,
	output drive_t           spindleDrive,
	output spindle_mode_t    spindleModeOut,
	output logic             frameSyncLocked,
	output logic             slowRotationFlag
);
	localparam int TW = $clog2(HOLD_CYCLES + 1);

	if (HOLD_CYCLES < 256)
		$error("HOLD_CYCLES must cover a brake pulse of 255");

	sync_if sync ();

	frame_sync_monitor fsm_u (
		.core_clk        (core_clk),
		.rst_n           (rst_n),
		.writeFrameClock (writeFrameClock),
		.frameSyncIn     (frameSyncIn),
		.frameCountIn    (frameCountIn),
		.sync            (sync.mon)
	);

	// Half of the requested distance, rounded up
	function automatic logic [5:0] presetFor(input logic [2:0] sel);
		case (sel)
			3'h0: presetFor = 6'h01;
			3'h1: presetFor = 6'h02;
			3'h2: presetFor = 6'h05;
			default: presetFor = 6'h10;
		endcase
	endfunction

	// Clamp a wide value into the drive range
	function automatic drive_t sat(input logic signed [15:0] v);
		if (v > 16'sh07ff)
			sat = 12'sh7ff;
		else if (v < -16'sh0800)
			sat = 12'sh800;
		else
			sat = v[11:0];
	endfunction

	// State
	logic [3:0]          ctrlCnt_q, ctrlCnt_d;
	logic                pend_q, pend_d;
	logic [2:0]          pCode_q, pCode_d;
	logic [7:0]          pArg_q, pArg_d;
	logic [7:0]          brakeLen_q, brakeLen_d;
	focus_state_t        focState_q, focState_d;
	drive_t              search_q, search_d;
	logic                searchUp_q, searchUp_d;
	logic                fzLatch_q, fzLatch_d;
	logic                feAbove_q, feAbove_d;
	jump_state_t         jmpState_q, jmpState_d;
	logic [5:0]          jumpCnt_q, jumpCnt_d;
	logic [1:0]          repLeft_q, repLeft_d;
	logic [TW-1:0]       timer_q, timer_d;
	logic                jumpRev_q, jumpRev_d;
	logic                tzcPrev_q, tzcPrev_d;
	logic                slipFwd_q, slipFwd_d;
	logic signed [15:0]  lpf_q, lpf_d;
	spindle_mode_t       cmdMode_q, cmdMode_d;
	logic                efmPrev_q, efmPrev_d;
	logic [7:0]          runCnt_q, runCnt_d;
	logic [7:0]          winMax_q, winMax_d;
	logic [7:0]          winCnt_q, winCnt_d;
	logic [7:0]          longest_q, longest_d;
	logic                slow_q, slow_d;
	drive_t              focDrv_d, trkDrv_d, carDrv_d, spnDrv_d;
	logic                boost_d;
	// Combinational helpers
	logic                ctrlTick, apply, tzcEdge, closeNow;
	logic signed [15:0]  carrEq, carrAbs;
	spindle_mode_t       effMode;

	// Only one command waits for the next boundary
	assign cmdReady = !pend_q;
	assign ctrlTick = (ctrlCnt_q == 4'(`CTRL_DIV - 1));
	assign apply = pend_q && ctrlTick;
	assign tzcEdge = trackZeroCross && !tzcPrev_q;

	// Command latch and control-cycle divider
	always_comb
	begin
		ctrlCnt_d = ctrlCnt_q + 4'h1;
		pend_d = pend_q;
		pCode_d = pCode_q;
		pArg_d = pArg_q;
		brakeLen_d = brakeLen_q;
		cmdMode_d = cmdMode_q;
		if (apply)
		begin
			pend_d = 1'b0;
			if (pCode_q == `CMD_SPINDLE && pArg_q[2:0] <= 3'h5)
				cmdMode_d = spindle_mode_t'(pArg_q[2:0]);
			if (pCode_q == `CMD_BRAKE_LEN && pArg_q != 8'h00)
				brakeLen_d = pArg_q;
		end
		if (cmdValid && cmdReady)
		begin
			pend_d = 1'b1;
			pCode_d = cmdCode;
			pArg_d = cmdArg;
		end
	end

	// Focus search ramp and close detection
	always_comb
	begin
		focState_d = focState_q;
		search_d = search_q;
		searchUp_d = searchUp_q;
		fzLatch_d = fzLatch_q;
		feAbove_d = (focusError >= focusZeroThreshold);
		focDrv_d = 12'sh000;
		closeNow = searchUp_q && reflectPresentFlag && fzLatch_q;
		case (focState_q)
			FOC_IDLE:
				if (apply && pCode_q == `CMD_FOCUS_SEARCH)
				begin
					focState_d = FOC_SEARCH;
					search_d = 12'sh000;
					searchUp_d = 1'b1;
					fzLatch_d = 1'b0;
				end
			FOC_SEARCH:
			begin
				// Triangle sweep, bounce at the limits
				if (searchUp_q)
					search_d = search_q + `SEARCH_STEP;
				else
					search_d = search_q - `SEARCH_STEP;
				if (search_q >= `SEARCH_LIMIT)
					searchUp_d = 1'b0;
				else if (search_q <= -`SEARCH_LIMIT)
					searchUp_d = 1'b1;
				// Latch only on a fresh threshold crossing
				if (feAbove_d && !feAbove_q)
					fzLatch_d = 1'b1;
				focDrv_d = search_d;
				if (closeNow)
					focState_d = FOC_CLOSED;
			end
			FOC_CLOSED:
				if (apply && pCode_q == `CMD_FOCUS_OFF)
					focState_d = FOC_IDLE;
			default:
				focState_d = FOC_IDLE;
		endcase
		if (focState_q != FOC_IDLE && apply && pCode_q == `CMD_FOCUS_OFF)
			focState_d = FOC_IDLE;
	end

	// Jump sequencer with brake pulse and hold
	always_comb
	begin
		jmpState_d = jmpState_q;
		jumpCnt_d = jumpCnt_q;
		repLeft_d = repLeft_q;
		timer_d = timer_q;
		jumpRev_d = jumpRev_q;
		tzcPrev_d = trackZeroCross;
		slipFwd_d = slipFwd_q;
		trkDrv_d = 12'sh000;
		if (tzcEdge)
			slipFwd_d = offTrackIndicator;
		case (jmpState_q)
			JMP_IDLE, JMP_HOLD:
			begin
				if (jmpState_q == JMP_HOLD)
				begin
					// Oppose slip only while between tracks
					if (offTrackIndicator)
						trkDrv_d = slipFwd_q ? -`BRAKE_DRIVE
							: `BRAKE_DRIVE;
					timer_d = timer_q - TW'(1);
					if (timer_q == TW'(1))
						jmpState_d = JMP_IDLE;
				end
				if (apply && pCode_q == `CMD_JUMP
					&& pArg_q[2:0] <= 3'h4)
				begin
					jmpState_d = JMP_RUN;
					jumpCnt_d = presetFor(pArg_q[2:0]);
					repLeft_d = (pArg_q[2:0] == 3'h4) ? 2'h2 : 2'h0;
					jumpRev_d = pArg_q[`ARG_DIR_BIT];
				end
			end
			JMP_RUN:
			begin
				trkDrv_d = jumpRev_q ? -`JUMP_KICK : `JUMP_KICK;
				if (tzcEdge)
				begin
					jumpCnt_d = jumpCnt_q - 6'h01;
					if (jumpCnt_q == 6'h01)
					begin
						jmpState_d = JMP_BRAKE;
						timer_d = TW'(brakeLen_q);
					end
				end
			end
			JMP_BRAKE:
			begin
				trkDrv_d = jumpRev_q ? `BRAKE_DRIVE : -`BRAKE_DRIVE;
				timer_d = timer_q - TW'(1);
				if (timer_q == TW'(1))
				begin
					if (repLeft_q != 2'h0)
					begin
						// Next leg of the triple 32-track jump
						jmpState_d = JMP_RUN;
						jumpCnt_d = presetFor(3'h3);
						repLeft_d = repLeft_q - 2'h1;
					end
					else
					begin
						jmpState_d = JMP_HOLD;
						timer_d = TW'(HOLD_CYCLES);
					end
				end
			end
			default:
				jmpState_d = JMP_IDLE;
		endcase
		boost_d = (jmpState_d == JMP_HOLD);
	end

	// Carriage: one-pole low-pass, fixed gain, dead zone
	always_comb
	begin
		lpf_d = lpf_q + ((16'(trackingEqOut) - lpf_q) >>> `LPF_SHIFT);
		carrEq = lpf_q <<< `CARR_GAIN_SHIFT;
		carrAbs = (carrEq < 0) ? -carrEq : carrEq;
		// Below threshold the motor would only stall and burn power
		carDrv_d = (carrAbs > $signed(`CARR_THRESH)) ? sat(carrEq)
			: 12'sh000;
	end

	// Spindle modes and run-length speed estimate
	always_comb
	begin
		effMode = cmdMode_q;
		if (cmdMode_q == SP_APPLIC && focState_q != FOC_CLOSED)
			effMode = SP_OFFSET;
		efmPrev_d = efmBit;
		runCnt_d = (runCnt_q == 8'hff) ? runCnt_q : runCnt_q + 8'h01;
		winMax_d = winMax_q;
		winCnt_d = winCnt_q + 8'h01;
		longest_d = longest_q;
		if (efmBit != efmPrev_q)
		begin
			runCnt_d = 8'h01;
			if (runCnt_q > winMax_q)
				winMax_d = runCnt_q;
		end
		if (winCnt_q == `RUN_WINDOW)
		begin
			// A stalled stream still counts as a long run
			longest_d = (runCnt_q > winMax_d) ? runCnt_q : winMax_d;
			winMax_d = 8'h00;
			winCnt_d = 8'h00;
		end
		slow_d = slow_q;
		if (effMode != SP_BRAKE)
			slow_d = 1'b0;
		if (effMode == SP_BRAKE && longest_q > `SLOW_RUN)
			slow_d = 1'b1;
		case (effMode)
			SP_STOP: spnDrv_d = 12'sh000;
			SP_KICK: spnDrv_d = `SPIN_KICK;
			SP_OFFSET: spnDrv_d = `SPIN_OFFSET;
			SP_APPLIC: spnDrv_d = sync.locked ? spinErrLocked
				: spinErrRegular;
			SP_BRAKE: spnDrv_d = `SPIN_BRAKE;
			SP_ROUGH: spnDrv_d = (longest_q > `NOMINAL_RUN)
				? `ROUGH_HIGH : `ROUGH_LOW;
			default: spnDrv_d = 12'sh000;
		endcase
	end

	// Register all state and data outputs
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			ctrlCnt_q <= 4'h0;
			pend_q <= 1'b0;
			pCode_q <= 3'h0;
			pArg_q <= 8'h00;
			brakeLen_q <= `BRAKE_LEN_RST;
			focState_q <= FOC_IDLE;
			search_q <= 12'sh000;
			searchUp_q <= 1'b1;
			fzLatch_q <= 1'b0;
			feAbove_q <= 1'b0;
			jmpState_q <= JMP_IDLE;
			jumpCnt_q <= 6'h00;
			repLeft_q <= 2'h0;
			timer_q <= '0;
			jumpRev_q <= 1'b0;
			tzcPrev_q <= 1'b0;
			slipFwd_q <= 1'b0;
			lpf_q <= 16'sh0000;
			cmdMode_q <= SP_STOP;
			efmPrev_q <= 1'b0;
			runCnt_q <= 8'h00;
			winMax_q <= 8'h00;
			winCnt_q <= 8'h00;
			longest_q <= 8'h00;
			slow_q <= 1'b0;
			focusDrive <= 12'sh000;
			trackDrive <= 12'sh000;
			carriageDrive <= 12'sh000;
			spindleDrive <= 12'sh000;
			trackGainBoost <= 1'b0;
		end
		else
		begin
			ctrlCnt_q <= ctrlCnt_d;
			pend_q <= pend_d;
			pCode_q <= pCode_d;
			pArg_q <= pArg_d;
			brakeLen_q <= brakeLen_d;
			focState_q <= focState_d;
			search_q <= search_d;
			searchUp_q <= searchUp_d;
			fzLatch_q <= fzLatch_d;
			feAbove_q <= feAbove_d;
			jmpState_q <= jmpState_d;
			jumpCnt_q <= jumpCnt_d;
			repLeft_q <= repLeft_d;
			timer_q <= timer_d;
			jumpRev_q <= jumpRev_d;
			tzcPrev_q <= tzcPrev_d;
			slipFwd_q <= slipFwd_d;
			lpf_q <= lpf_d;
			cmdMode_q <= cmdMode_d;
			efmPrev_q <= efmPrev_d;
			runCnt_q <= runCnt_d;
			winMax_q <= winMax_d;
			winCnt_q <= winCnt_d;
			longest_q <= longest_d;
			slow_q <= slow_d;
			focusDrive <= focDrv_d;
			trackDrive <= trkDrv_d;
			carriageDrive <= carDrv_d;
			spindleDrive <= spnDrv_d;
			trackGainBoost <= boost_d;
		end
	end

	// Status levels straight from state registers
	assign focusClosed_n = (focState_q != FOC_CLOSED);
	assign focusLoopOn = (focState_q == FOC_CLOSED);
	assign trackLoopOn = (jmpState_q == JMP_IDLE || jmpState_q == JMP_HOLD);
	assign jumpBusy = (jmpState_q != JMP_IDLE);
	assign spindleModeOut = cmdMode_q;
	assign frameSyncLocked = sync.locked;
	assign slowRotationFlag = slow_q;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	AST_FOCUS_CLOSE: assert property (
		$rose(focState_q == FOC_CLOSED) |->
		$past(searchUp_q && reflectPresentFlag && fzLatch_q))
		else $error("focus closed without all three conditions");
	AST_CLOSED_FALL: assert property (
		$past(focState_q == FOC_SEARCH && closeNow
		&& !(apply && pCode_q == `CMD_FOCUS_OFF)) |-> $fell(focusClosed_n))
		else $error("focus-closed output did not fall");
	AST_JUMP_PRESET: assert property (
		$past(jmpState_q == JMP_IDLE || jmpState_q == JMP_HOLD)
		&& jmpState_q == JMP_RUN
		&& $past(pArg_q[2:0]) == 3'h2 |-> jumpCnt_q == 6'h05)
		else $error("ten-track jump not preset to five");
	AST_BRAKE_LEN: assert property (
		$rose(jmpState_q == JMP_BRAKE) |-> timer_q == TW'(brakeLen_q))
		else $error("brake pulse length not as commanded");
	AST_HOLD_BOOST: assert property (
		$rose(jmpState_q == JMP_HOLD) |->
		trackGainBoost && timer_q == TW'(HOLD_CYCLES) && trackLoopOn)
		else $error("hold phase without boost or full time");
	AST_BRAKE_OPPOSE: assert property (
		$past(jmpState_q == JMP_HOLD) && trackDrive != 12'sh000 |->
		(trackDrive > 0) == !$past(slipFwd_q))
		else $error("brake drive not opposing slip");
	AST_CARR_GATE: assert property (
		carriageDrive != 12'sh000 |-> $past(carrAbs > $signed(`CARR_THRESH)))
		else $error("carriage driven below threshold");
	AST_OFFSET_LOSS: assert property (
		cmdMode_q == SP_APPLIC && focState_q != FOC_CLOSED |->
		##1 spindleDrive == `SPIN_OFFSET)
		else $error("no offset drive during focus loss");
	AST_STOP_ZERO: assert property (
		cmdMode_q == SP_STOP |-> ##1 spindleDrive == 12'sh000)
		else $error("spindle driven in stop mode");
	AST_CMD_BOUNDARY: assert property (
		$changed(cmdMode_q) |-> $past(ctrlTick))
		else $error("mode changed off the control boundary");
endmodule

// File: testbench/host_model.sv
`timescale 1ns/100ps
module host_model
#(
	parameter int MONITOR_DELAY = 400000
)
(
	// Clock and reset
	input  wire logic  core_clk,
	input  wire logic  rst_n,
	// Command bus toward the device
	output logic       cmdValid,
	output logic [2:0] cmdCode,
	output logic [7:0] cmdArg,
	input  wire logic  cmdReady,
	// Status watched for protection
	input  wire logic  focusClosed_n,
	input  wire logic  reflectPresentFlag,
	output logic       protectSeen
);
	int waitCnt;

	// Bus idle from time zero
	initial
	begin
		cmdValid = 1'b0;
		cmdCode = 3'h0;
		cmdArg = 8'h00;
	end

	// Hold the command until taken, then wait for the apply edge
	task automatic issue(input logic [2:0] code, input logic [7:0] arg,
		output int n);
		n = 0;
		@(posedge core_clk);
		cmdValid <= 1'b1;
		cmdCode <= code;
		cmdArg <= arg;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (cmdReady !== 1'b1 && n < 40);
		cmdValid <= 1'b0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (cmdReady !== 1'b1 && n < 80);
	endtask

	// Reflection is ignored until the settle delay after close runs out
	always @(posedge core_clk)
	begin
		if (!rst_n || focusClosed_n !== 1'b0)
			waitCnt <= 0;
		else if (waitCnt < MONITOR_DELAY)
			waitCnt <= waitCnt + 1;
		protectSeen <= rst_n && waitCnt >= MONITOR_DELAY
			&& !reflectPresentFlag;
	end
endmodule

// File: testbench/optical_disc_servo_sequencer_test.sv
`timescale 1ns/100ps
`include "servo_consts.svh"
module optical_disc_servo_sequencer_test
	import servo_pkg::*;
;
	logic          core_clk, rst_n, cmdValid, cmdReady, protectSeen;
	logic [2:0]    cmdCode;
	logic [7:0]    cmdArg;
	drive_t        focusError, focusZeroThreshold, trackingEqOut;
	drive_t        spinErrLocked, spinErrRegular;
	drive_t        focusDrive, trackDrive, carriageDrive, spindleDrive;
	logic          reflectPresentFlag, trackZeroCross, offTrackIndicator;
	logic          writeFrameClock, frameSyncIn, frameCountIn, efmBit;
	logic          focusLoopOn, focusClosed_n, trackLoopOn, trackGainBoost;
	logic          jumpBusy, frameSyncLocked, slowRotationFlag;
	spindle_mode_t spindleModeOut;
	int            err_count = 0;
	int            num_checks = 0;
	int            jumpPre [5] = '{1, 2, 5, 16, 16};
	int            jumpReps [5] = '{1, 1, 1, 1, 3};
	logic [7:0]    modeArg [4] = '{8'h01, 8'h02, 8'h00, 8'h06};
	drive_t        modeExp [4] = '{`SPIN_KICK, `SPIN_OFFSET, 12'sh0, 12'sh0};

	// Short hold so each jump finishes quickly
	optical_disc_servo_sequencer #(.HOLD_CYCLES(300)) dut (.core_clk, .rst_n,
		.cmdValid, .cmdCode, .cmdArg, .cmdReady, .focusError,
		.focusZeroThreshold, .reflectPresentFlag, .trackZeroCross,
		.offTrackIndicator, .trackingEqOut, .writeFrameClock, .frameSyncIn,
		.frameCountIn, .efmBit, .spinErrLocked, .spinErrRegular, .focusDrive,
		.focusLoopOn, .focusClosed_n, .trackDrive, .trackLoopOn,
		.trackGainBoost, .jumpBusy, .carriageDrive, .spindleDrive,
		.spindleModeOut, .frameSyncLocked, .slowRotationFlag);
	host_model #(.MONITOR_DELAY(64)) host (.core_clk, .rst_n, .cmdValid,
		.cmdCode, .cmdArg, .cmdReady, .focusClosed_n, .reflectPresentFlag,
		.protectSeen);

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [11:0] seen,
		input logic [11:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// A used-up wait counts and ends the run
	task automatic bound(input int n, input int lim);
		if (n >= lim)
		begin
			err_count++;
			$display("[ERR] wait expected done seen timeout");
			close_out();
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
	endtask

	task automatic cmd(input logic [2:0] code, input logic [7:0] arg);
		int n;
		host.issue(code, arg, n);
		bound(n, 80);
		cyc(2);
	endtask

	// Frame clock edges spaced four cycles, inputs settled beforehand
	task automatic frames(input int k, input logic s, input logic c);
		frameSyncIn <= s;
		frameCountIn <= c;
		repeat (k)
		begin
			writeFrameClock <= 1'b1;
			cyc(2);
			writeFrameClock <= 1'b0;
			cyc(2);
		end
		cyc(4);
	endtask

	// Short runs in the bit stream: fast rotation
	task automatic efm(input int k);
		repeat (k)
		begin
			efmBit <= ~efmBit;
			cyc(8);
		end
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// Watchdog over the whole run
	initial
	begin
		cyc(40000);
		bound(1, 1);
	end

	initial
	begin
		int n;
		int bc;
		int hc;
		drive_t d0;
		rst_n = 1'b0;
		{focusError, focusZeroThreshold, trackingEqOut} = '0;
		{spinErrLocked, spinErrRegular} = '0;
		{reflectPresentFlag, trackZeroCross, offTrackIndicator} = '0;
		{writeFrameClock, frameSyncIn, frameCountIn, efmBit} = '0;
		cyc(12);
		rst_n <= 1'b1;
		cyc(1);
		check("ready", cmdReady, 1'b1);
		check("closed_n", focusClosed_n, 1'b1);
		check("locked", frameSyncLocked, 1'b1);
		check("mode", spindleModeOut, SP_STOP);
		check("spindle", spindleDrive, 12'sh0);
		// Carriage drive gated by threshold after low-pass and gain
		trackingEqOut <= 12'sh040;
		cyc(100);
		check("carriage low", carriageDrive, 12'sh0);
		trackingEqOut <= 12'sh7ff;
		cyc(100);
		check("carriage high", carriageDrive != 12'sh0, 1'b1);
		trackingEqOut <= 12'sh0;
		cyc(150);
		check("carriage off", carriageDrive, 12'sh0);
		for (int i = 0; i < 4; i++)
		begin
			cmd(`CMD_SPINDLE, modeArg[i]);
			check("spin mode", spindleDrive, modeExp[i]);
		end
		check("refused mode", spindleModeOut, SP_STOP);
		// Search with no reflection must not close
		cmd(`CMD_SPINDLE, 8'h01);
		cmd(`CMD_FOCUS_SEARCH, 8'h00);
		focusZeroThreshold <= 12'sh080;
		focusError <= -12'sh100;
		cyc(5);
		focusError <= 12'sh100;
		d0 = focusDrive;
		cyc(1);
		check("step", focusDrive - d0 == 4 || d0 - focusDrive == 4,
			1'b1);
		check("kicked", spindleDrive, `SPIN_KICK);
		cyc(1200);
		check("no close", focusClosed_n, 1'b1);
		reflectPresentFlag <= 1'b1;
		focusError <= -12'sh100;
		cyc(5);
		focusError <= 12'sh100;
		n = 0;
		while (focusClosed_n !== 1'b0 && n < 1200)
		begin
			cyc(1);
			n++;
		end
		bound(n, 1200);
		check("loop on", focusLoopOn, 1'b1);
		cyc(100);
		check("protect", protectSeen, 1'b0);
		// Lock lost on the eighth miss only
		cmd(`CMD_SPINDLE, 8'h03);
		spinErrLocked <= 12'sh123;
		spinErrRegular <= 12'sh0ab;
		frames(112, 1'b1, 1'b0);
		check("seven misses", frameSyncLocked, 1'b1);
		check("locked servo", spindleDrive, 12'sh123);
		frames(16, 1'b1, 1'b0);
		check("eight misses", frameSyncLocked, 1'b0);
		check("regular servo", spindleDrive, 12'sh0ab);
		frames(16, 1'b1, 1'b1);
		check("relock", frameSyncLocked, 1'b1);
		// Every jump size, counted brake pulse and timed hold
		cmd(`CMD_BRAKE_LEN, 8'h04);
		for (int j = 0; j < 5; j++)
		begin
			cmd(`CMD_JUMP, 8'(j));
			hc = 0;
			check("busy", jumpBusy, 1'b1);
			check("kick", trackDrive, `JUMP_KICK);
			for (int r = 0; r < jumpReps[j]; r++)
			begin
				bc = 0;
				for (int t = 0; t < jumpPre[j]; t++)
				begin
					check("loop open", trackLoopOn, 1'b0);
					trackZeroCross <= 1'b1;
					cyc(1);
					trackZeroCross <= 1'b0;
					repeat (12)
					begin
						cyc(1);
						bc += (trackDrive === 12'she00);
						hc += (trackGainBoost === 1'b1);
					end
				end
				check("brake len", bc[11:0], 12'h004);
			end
			n = 0;
			while (jumpBusy === 1'b1 && n < 400)
			begin
				cyc(1);
				n++;
				hc += (trackGainBoost === 1'b1);
				offTrackIndicator <= (n >= 20 && n < 40);
				if (n == 10)
					check("closed", trackLoopOn, 1'b1);
				if (n == 30)
					check("slip", trackDrive == 12'sh200
						|| trackDrive == 12'she00, 1'b1);
				if (n == 50)
					check("on track", trackDrive, 12'sh0);
			end
			bound(n, 400);
			check("hold", hc[11:0], 12'd300);
			check("boost off", trackGainBoost, 1'b0);
		end
		cmd(`CMD_JUMP, 8'h05);
		check("bad jump", jumpBusy, 1'b0);
		// Rough servo, then brake until slow, then stop
		cmd(`CMD_SPINDLE, 8'h05);
		check("rough slow", spindleDrive, `ROUGH_HIGH);
		efm(70);
		check("rough fast", spindleDrive, `ROUGH_LOW);
		cmd(`CMD_SPINDLE, 8'h04);
		check("brake drive", spindleDrive, `SPIN_BRAKE);
		efm(38);
		check("fast", slowRotationFlag, 1'b0);
		cyc(400);
		check("slow", slowRotationFlag, 1'b1);
		cmd(`CMD_SPINDLE, 8'h00);
		check("stop", spindleDrive, 12'sh0);
		check("flag clear", slowRotationFlag, 1'b0);
		cmd(`CMD_FOCUS_OFF, 8'h00);
		check("opened", focusClosed_n, 1'b1);
		check("loop off", focusLoopOn, 1'b0);
		cmd(`CMD_SPINDLE, 8'h03);
		check("focus lost", spindleDrive, `SPIN_OFFSET);
		close_out();
	end
endmodule
